// >>> core/exc_vec_pkg.sv
/*
 * constants, field layouts and carrier types shared by the exception
 * prioritisation and vectoring block.
 * assumes one 40 MHz clock and an active-low asynchronous chip reset.
 */
package exc_vec_pkg;

    // ************************************************************
    // register offsets of the plain register port
    // ************************************************************
    localparam logic [7:0] OFS_EXT_PIN_CTRL   = 8'h1E;
    localparam logic [7:0] OFS_PRIO_PROMOTION = 8'h1F;

    // ************************************************************
    // external pin control register fields
    // ************************************************************
    localparam int         BIT_EDGE_ONLY   = 7;
    localparam int         BIT_PIN_CONNECT = 6;
    localparam logic [7:0] PIN_CTRL_RESET  = 8'h40;

    // ************************************************************
    // vector map: slot k holds vector 0xFFF2 - 2k
    // ************************************************************
    localparam int          NUM_SLOTS        = 57;
    localparam logic [15:0] VEC_RESET        = 16'hFFFE;
    localparam logic [15:0] VEC_CLK_MONITOR  = 16'hFFFC;
    localparam logic [15:0] VEC_WATCHDOG     = 16'hFFFA;
    localparam logic [15:0] VEC_TRAP         = 16'hFFF8;
    localparam logic [15:0] VEC_SOFT_INT     = 16'hFFF6;
    localparam logic [15:0] VEC_NONMASKABLE  = 16'hFFF4;
    localparam logic [7:0]  VEC_HIGH_BYTE    = 8'hFF;
    localparam logic [7:0]  TOP_MASKABLE_LSB = 8'hF2;
    localparam logic [7:0]  LOW_MASKABLE_LSB = 8'h82;
    localparam logic [7:0]  PROMO_RESET      = 8'hF2;

    // slot indices of the implemented maskable sources
    localparam int SLOT_EXT_PIN      = 0;
    localparam int SLOT_PERIODIC     = 1;
    localparam int SLOT_CAPTURE0     = 2;
    localparam int SLOT_CNT_OVF      = 10;
    localparam int SLOT_ACC_A_OVF    = 11;
    localparam int SLOT_ACC_A_EDGE   = 12;
    localparam int SLOT_SERIAL_PERIPH = 13;
    localparam int SLOT_SERIAL_COMM0 = 14;
    localparam int SLOT_SERIAL_COMM1 = 15;
    localparam int SLOT_CONVERTER    = 16;
    localparam int SLOT_MOD_UNDERFLOW = 20;
    localparam int SLOT_ACC_B_OVF    = 21;
    localparam int SLOT_CLK_LOCK     = 22;
    localparam int SLOT_SELF_CLOCK   = 23;
    localparam int SLOT_FLASH        = 29;
    localparam int SLOT_PWM_SHUTDOWN = 51;

    // implemented maskable slots; the rest are reserved vector slots
    localparam logic [NUM_SLOTS-1:0] SLOT_IMPL = 57'h0_0008_0000_20F1_FFFF;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic clk_monitor_reset;
        logic watchdog_reset;
        logic trap;
        logic soft_int;
    } nonmaskable_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage : exc_vec_pkg

// >>> core/pin_sync3.sv
/*
 * three-stage synchroniser for one asynchronous pin.
 * assumes the pin is asynchronous to core_clk_i; the output changes once
 * the second and third stages agree.
 */
`timescale 1ns/1ps
module pin_sync3 (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // pin side
    input  wire logic pin_i,
    input  wire logic reset_level_i,
    // core side
    output logic      level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // first stage feeds only the second
    always_comb begin
        state_next     = state_reg;
        state_next.s1  = pin_i;
        state_next.s2  = state_reg.s1;
        state_next.s3  = state_reg.s2;
        if (state_reg.s2 == state_reg.s3) begin
            state_next.lvl = state_reg.s3;
        end
    end

    // reset takes constants only, the level input is a tie-off constant
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_o = state_reg.lvl & reset_level_i;
endmodule : pin_sync3

// >>> core/slot_arbiter.sv
/*
 * fixed-order priority picker over the maskable slots.
 * assumes slot 0 is the highest default priority; purely combinational.
 */
`timescale 1ns/1ps
module slot_arbiter #(
    parameter int N = 57
) (
    // request side
    input  wire logic [N-1:0] req_i,
    // answer side
    output logic              any_o,
    output logic [7:0]        index_o
);
    // scan from the lowest priority upward so the top one wins
    always_comb begin
        any_o   = 1'b0;
        index_o = 8'h00;
        for (int k = N - 1; k >= 0; k--) begin
            if (req_i[k]) begin
                any_o   = 1'b1;
                index_o = k[7:0];
            end
        end
    end
endmodule : slot_arbiter

// >>> core/exception_priority_vectoring.sv
/*
 * exception prioritisation and vectoring: ranks resets, non-maskable
 * requests and the maskable slots and hands the cpu a 16-bit vector.
 * assumes a cpu that pulses ack_i on the vector fetch and reports its
 * x and i mask bits, peripherals that hold their own flags and enables,
 * and asynchronous external pins, both active low.
 */
// Operation
// - one 16-bit vector per source, top 128 bytes
// - top six vectors for resets and non-maskables
// - fixed non-maskable ranking, reset highest
// - nonmaskable pin accepted only when x is zero
// - fixed vectors FFFE down to FFF4
// - maskable sources need i mask cleared
// - i mask resets to one, writable anytime
// - one maskable source promotable, others keep order
// - promoted source still masked, same vector
// - promotion writes only while i is set
// - promotion code is vector low byte
// - default order by descending vector address
// - capture timer vector assignments
// - remaining peripheral vector assignments
// - reserved slots keep place, never active
// - nonmaskable pin level, external pin level/edge
// - nothing pending at fetch gives trap vector
// - edge latched, cleared when serviced
// - other sources held by peripheral flag bits
// - bad promotion code falls back to FFF2
// - reset loads F2 promotion and level mode
// - connect bit zero detaches pin and latch
// - edge-only bit write-once in normal modes
`timescale 1ns/1ps
module exception_priority_vectoring (
    // clock and reset
    input  wire logic                                core_clk_i,
    input  wire logic                                rst_n_i,
    // register port
    input  wire exc_vec_pkg::reg_req_t               reg_req_i,
    output logic [7:0]                               reg_rdata_o,
    // cpu core
    input  wire logic                                x_mask_i,
    input  wire logic                                i_mask_i,
    input  wire logic                                ack_i,
    input  wire logic                                special_mode_i,
    output logic                                     req_o,
    output logic                                     nonmaskable_req_o,
    output logic [15:0]                              vector_o,
    output logic                                     vector_valid_o,
    // reset and non-maskable sources
    input  wire logic                                power_reset_i,
    input  wire exc_vec_pkg::nonmaskable_t           nonmaskable_i,
    // external pins, active low
    input  wire logic                                nonmaskable_pin_n_i,
    input  wire logic                                ext_irq_pin_n_i,
    // peripheral flags already anded with local enables
    input  wire logic [exc_vec_pkg::NUM_SLOTS-1:0]   periph_req_i
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic        edge_only_select;
        logic        external_pin_connect;
        logic        edge_written;
        logic [7:0]  priority_promotion_reg;
        logic        edge_latch;
        logic        pin_prev;
        logic [7:0]  rdata;
        logic        req;
        logic        nmi_req;
        logic [15:0] vector;
        logic        vector_valid;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    logic nmi_pin_level;
    logic irq_pin_level;
    logic [exc_vec_pkg::NUM_SLOTS-1:0] slot_req;
    logic        any_pending;
    logic [7:0]  top_index;
    logic [7:0]  promo_index;
    logic        promo_valid;
    logic        promo_hit;
    logic [7:0]  win_index;
    logic        ext_pin_active;
    logic        nmi_active;
    logic        fall_edge;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    pin_sync3 u_sync_nmi (
        .core_clk_i    (core_clk_i),
        .rst_n_i       (rst_n_i),
        .pin_i         (nonmaskable_pin_n_i),
        .reset_level_i (1'b1),
        .level_o       (nmi_pin_level)
    );

    pin_sync3 u_sync_irq (
        .core_clk_i    (core_clk_i),
        .rst_n_i       (rst_n_i),
        .pin_i         (ext_irq_pin_n_i),
        .reset_level_i (1'b1),
        .level_o       (irq_pin_level)
    );

    // ************************************************************
    // request gathering
    // ************************************************************
    // nonmaskable pin is level only and gated by x
    assign nmi_active = ~nmi_pin_level & ~x_mask_i;

    assign fall_edge = state_reg.pin_prev & ~irq_pin_level;

    // the pin counts only when connected; edge mode reads the latch
    assign ext_pin_active = state_reg.external_pin_connect &
        (state_reg.edge_only_select ? state_reg.edge_latch
                                    : ~irq_pin_level);

    // reserved slots are forced idle, maskables need i cleared
    always_comb begin
        slot_req = periph_req_i & exc_vec_pkg::SLOT_IMPL;
        slot_req[exc_vec_pkg::SLOT_EXT_PIN] = ext_pin_active;
        if (i_mask_i) begin
            slot_req = '0;
        end
    end

    slot_arbiter #(
        .N (exc_vec_pkg::NUM_SLOTS)
    ) u_arbiter (
        .req_i   (slot_req),
        .any_o   (any_pending),
        .index_o (top_index)
    );

    // ************************************************************
    // promotion decode
    // ************************************************************
    // code is the vector low byte; slot = (F2 - code) / 2
    always_comb begin
        logic [7:0] diff;
        diff        = exc_vec_pkg::TOP_MASKABLE_LSB - state_reg.priority_promotion_reg;
        promo_index = {1'b0, diff[7:1]};
        promo_valid = (state_reg.priority_promotion_reg <= exc_vec_pkg::TOP_MASKABLE_LSB) &&
                      (state_reg.priority_promotion_reg >= exc_vec_pkg::LOW_MASKABLE_LSB) &&
                      !state_reg.priority_promotion_reg[0] &&
                      exc_vec_pkg::SLOT_IMPL[promo_index[5:0]];
        // invalid code leaves slot 0 on top, which is already default
        promo_hit   = promo_valid && slot_req[promo_index[5:0]];
        win_index   = promo_hit ? promo_index : top_index;
    end

    // ************************************************************
    // register port and vector resolution
    // ************************************************************
    always_comb begin
        state_next              = state_reg;
        state_next.pin_prev     = irq_pin_level;
        state_next.vector_valid = 1'b0;
        state_next.rdata        = 8'h00;

        // edge latch: set by a falling edge while connected in edge-only mode
        if (!state_reg.external_pin_connect || !state_reg.edge_only_select) begin
            state_next.edge_latch = 1'b0;
        end else if (fall_edge) begin
            state_next.edge_latch = 1'b1;
        end

        // register writes
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                exc_vec_pkg::OFS_EXT_PIN_CTRL: begin
                    state_next.external_pin_connect =
                        reg_req_i.wdata[exc_vec_pkg::BIT_PIN_CONNECT];
                    // write-once outside special modes
                    if (special_mode_i || !state_reg.edge_written) begin
                        state_next.edge_only_select =
                            reg_req_i.wdata[exc_vec_pkg::BIT_EDGE_ONLY];
                        state_next.edge_written     = 1'b1;
                    end
                end
                exc_vec_pkg::OFS_PRIO_PROMOTION: begin
                    if (i_mask_i) begin
                        state_next.priority_promotion_reg = reg_req_i.wdata;
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads, answered next cycle, unmapped reads zero
        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                exc_vec_pkg::OFS_EXT_PIN_CTRL: begin
                    state_next.rdata[exc_vec_pkg::BIT_EDGE_ONLY]   = state_reg.edge_only_select;
                    state_next.rdata[exc_vec_pkg::BIT_PIN_CONNECT] =
                        state_reg.external_pin_connect;
                end
                exc_vec_pkg::OFS_PRIO_PROMOTION: begin
                    state_next.rdata = state_reg.priority_promotion_reg;
                end
                default: begin
                end
            endcase
        end

        // request levels to the cpu
        state_next.nmi_req = power_reset_i | nonmaskable_i.clk_monitor_reset |
                             nonmaskable_i.watchdog_reset | nmi_active;
        state_next.req     = state_next.nmi_req | any_pending;

        // vector resolved from this cycle's sources on acknowledge
        if (ack_i) begin
            state_next.vector_valid = 1'b1;
            if (power_reset_i) begin
                state_next.vector = exc_vec_pkg::VEC_RESET;
            end else if (nonmaskable_i.clk_monitor_reset) begin
                state_next.vector = exc_vec_pkg::VEC_CLK_MONITOR;
            end else if (nonmaskable_i.watchdog_reset) begin
                state_next.vector = exc_vec_pkg::VEC_WATCHDOG;
            end else if (nonmaskable_i.trap) begin
                state_next.vector = exc_vec_pkg::VEC_TRAP;
            end else if (nonmaskable_i.soft_int) begin
                state_next.vector = exc_vec_pkg::VEC_SOFT_INT;
            end else if (nmi_active) begin
                state_next.vector = exc_vec_pkg::VEC_NONMASKABLE;
            end else if (any_pending) begin
                // slot k vectors to FFF2 - 2k, all inside FF80..FFFF
                state_next.vector = {exc_vec_pkg::VEC_HIGH_BYTE,
                    8'(exc_vec_pkg::TOP_MASKABLE_LSB - {win_index[6:0], 1'b0})};
                // serviced edge latch clears; a new edge wins the clear
                if (win_index == 8'h00 && state_reg.edge_only_select && !fall_edge) begin
                    state_next.edge_latch = 1'b0;
                end
            end else begin
                state_next.vector = exc_vec_pkg::VEC_TRAP;
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg                        <= '0;
            state_reg.external_pin_connect   <=
                exc_vec_pkg::PIN_CTRL_RESET[exc_vec_pkg::BIT_PIN_CONNECT];
            state_reg.priority_promotion_reg <= exc_vec_pkg::PROMO_RESET;
            state_reg.pin_prev               <= 1'b1;
            state_reg.vector                 <= exc_vec_pkg::VEC_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata_o       = state_reg.rdata;
    assign req_o             = state_reg.req;
    assign nonmaskable_req_o = state_reg.nmi_req;
    assign vector_o          = state_reg.vector;
    assign vector_valid_o    = state_reg.vector_valid;
    // the i mask itself lives in the cpu; i_mask_i must reset to one
endmodule : exception_priority_vectoring

// >>> verification/exc_vec_properties.sv
/* properties of the exception vectoring block, bound to its top module.
   assumes one clock domain and the active-low asynchronous reset. */
`timescale 1ns/1ps
module exc_vec_properties (
    // clock and reset
    input wire logic                      core_clk_i,
    input wire logic                      rst_n_i,
    // register port
    input wire exc_vec_pkg::reg_req_t     reg_req_i,
    input wire logic [7:0]                reg_rdata_o,
    // cpu side
    input wire logic                      x_mask_i,
    input wire logic                      i_mask_i,
    input wire logic                      ack_i,
    input wire logic                      req_o,
    input wire logic                      nonmaskable_req_o,
    input wire logic [15:0]               vector_o,
    input wire logic                      vector_valid_o,
    // sources
    input wire logic                      power_reset_i,
    input wire exc_vec_pkg::nonmaskable_t nonmaskable_i
);
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_valid_after: assert property (ack_i |=> vector_valid_o)
        else $error("no vector valid after ack");
    chk_valid_cause: assert property (vector_valid_o |-> $past(ack_i))
        else $error("vector valid without ack");
    chk_vector_hold: assert property (!ack_i |=> $stable(vector_o))
        else $error("vector moved without ack");
    chk_vector_window: assert property (vector_valid_o |->
        vector_o[15:7] == 9'h1FF && !vector_o[0])
        else $error("vector outside top 128 bytes");
    chk_reset_top: assert property (ack_i && power_reset_i |=> vector_o == 16'hFFFE)
        else $error("reset vector not taken");
    chk_clkmon_rank: assert property (ack_i && !power_reset_i
        && nonmaskable_i.clk_monitor_reset |=> vector_o == 16'hFFFC)
        else $error("clock monitor vector not taken");
    chk_watchdog_rank: assert property (ack_i && !power_reset_i
        && nonmaskable_i[3:2] == 2'h1 |=> vector_o == 16'hFFFA)
        else $error("watchdog vector not taken");
    chk_masked_trap: assert property (ack_i && !power_reset_i && nonmaskable_i == 4'h0
        && x_mask_i && i_mask_i |=> vector_o == 16'hFFF8)
        else $error("masked fetch did not give trap vector");
    chk_reset_req: assert property (power_reset_i |-> ##[1:2] nonmaskable_req_o)
        else $error("reset request not raised");
    chk_rdata_cause: assert property (reg_rdata_o != 8'h00 |-> $past(reg_req_i.rd))
        else $error("read data without read strobe");
    chk_masked_idle: assert property ((i_mask_i && x_mask_i && !power_reset_i
        && nonmaskable_i[3:2] == 2'h0)[*3] |-> !req_o)
        else $error("request raised while all masked");

    // main scenarios
    cov_open_ack: cover property (ack_i && !i_mask_i);
    cov_pin_nmi: cover property (vector_valid_o && vector_o == 16'hFFF4);
    cov_promo_wr: cover property (reg_req_i.wr && reg_req_i.addr == 8'h1F && i_mask_i);
endmodule : exc_vec_properties

bind exception_priority_vectoring exc_vec_properties chk_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .x_mask_i(x_mask_i), .i_mask_i(i_mask_i),
    .ack_i(ack_i), .req_o(req_o), .nonmaskable_req_o(nonmaskable_req_o),
    .vector_o(vector_o), .vector_valid_o(vector_valid_o), .power_reset_i(power_reset_i),
    .nonmaskable_i(nonmaskable_i));

// >>> verification/cpu_pin_model.sv
/* model of the cpu mask bits, vector fetch and the two interrupt pins.
   assumes bench commands arrive as one-cycle pulses or levels. */
`timescale 1ns/1ps
module cpu_pin_model (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // bench commands
    input  wire logic        i_open_i,
    input  wire logic        x_open_i,
    input  wire logic        fetch_i,
    input  wire logic        irq_set_i,
    input  wire logic        irq_drop_i,
    input  wire logic        nmi_set_i,
    // vector seen by the service routine
    input  wire logic [15:0] vector_i,
    input  wire logic        vector_valid_i,
    // toward the block
    output logic             i_mask_o,
    output logic             x_mask_o,
    output logic             ack_o,
    output logic             irq_pin_n_o,
    output logic             nmi_pin_n_o
);
    // masks come up set; pins rest high through their pull-ups
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            i_mask_o     <= 1'b1;
            x_mask_o     <= 1'b1;
            ack_o        <= 1'b0;
            irq_pin_n_o  <= 1'b1;
            nmi_pin_n_o  <= 1'b1;
        end else begin
            i_mask_o     <= !i_open_i;
            x_mask_o     <= !x_open_i;
            ack_o        <= fetch_i;
            // the nmi pin is let go only once its own vector was served; the ext pin also on irq_drop_i
            if (irq_set_i)
                irq_pin_n_o <= 1'b0;
            else if (irq_drop_i || (vector_valid_i && vector_i == 16'hFFF2))
                irq_pin_n_o <= 1'b1;
            if (nmi_set_i)
                nmi_pin_n_o <= 1'b0;
            else if (vector_valid_i && vector_i == 16'hFFF4)
                nmi_pin_n_o <= 1'b1;
        end
    end
endmodule : cpu_pin_model

// >>> verification/tb_top.sv
/* self-checking bench for the exception vectoring block.
   assumes the cpu pin model and the bound property checker. */
`timescale 1ns/1ps
module tb_top;
    logic                              core_clk_i;
    logic                              rst_n_i = 1'b0;
    exc_vec_pkg::reg_req_t             reg_req = '0;
    exc_vec_pkg::nonmaskable_t         nm_src = '0;
    logic [exc_vec_pkg::NUM_SLOTS-1:0] periph = '0;
    logic                              power_rst = 1'b0, special = 1'b0, fetch = 1'b0;
    logic                              i_open = 1'b0, x_open = 1'b0;
    logic                              irq_set = 1'b0, irq_drop = 1'b0, nmi_set = 1'b0;
    logic                              x_bit, i_bit, ack, irq_pin_n, nmi_pin_n, valid;
    logic [7:0]                        rdata;
    logic [15:0]                       vector;
    int                                n_mismatch = 0, checks = 0;
    int                                slots[19] = '{1, 2, 9, 10, 11, 12, 13, 14, 15, 16,
                                                     20, 21, 22, 23, 29, 51, 17, 18, 19};

    // 40 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    exception_priority_vectoring dut_u (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req),
        .reg_rdata_o(rdata), .x_mask_i(x_bit), .i_mask_i(i_bit), .ack_i(ack),
        .special_mode_i(special), .req_o(), .nonmaskable_req_o(), .vector_o(vector),
        .vector_valid_o(valid), .power_reset_i(power_rst), .nonmaskable_i(nm_src),
        .nonmaskable_pin_n_i(nmi_pin_n), .ext_irq_pin_n_i(irq_pin_n), .periph_req_i(periph));

    cpu_pin_model cpu_u (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .i_open_i(i_open), .x_open_i(x_open),
        .fetch_i(fetch), .irq_set_i(irq_set), .irq_drop_i(irq_drop), .nmi_set_i(nmi_set),
        .vector_i(vector), .vector_valid_i(valid), .i_mask_o(i_bit),
        .x_mask_o(x_bit), .ack_o(ack), .irq_pin_n_o(irq_pin_n), .nmi_pin_n_o(nmi_pin_n));

    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : cycles

    task automatic masks(input logic io, input logic xo);
        i_open <= io;
        x_open <= xo;
        cycles(2);
    endtask : masks

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        reg_req <= '0;
        @(posedge core_clk_i);
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        reg_req <= '0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
        @(posedge core_clk_i);
    endtask : rd

    // pin commands: 0 assert ext pin, 1 release it, 2 assert nmi pin
    task automatic pin(input int w);
        irq_set <= (w == 0);
        irq_drop <= (w == 1);
        nmi_set <= (w == 2);
        @(posedge core_clk_i);
        {irq_set, irq_drop, nmi_set} <= 3'h0;
        cycles(8); // covers the three-flop pin synchroniser
    endtask : pin

    task automatic vec(input logic [15:0] exp);
        fetch <= 1'b1;
        @(posedge core_clk_i);
        fetch <= 1'b0;
        @(posedge core_clk_i);
        #1 chk({15'h0, valid}, 16'h0001);
        chk(vector, exp);
        @(posedge core_clk_i);
    endtask : vec

    task automatic conclude();
        $display("n_mismatch=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        cycles(16);
        rst_n_i <= 1'b1;
        chk(vector, 16'hFFFE);
        cycles(1);
        rd(8'h1E, 8'h40);
        rd(8'h1F, 8'hF2);
        rd(8'h10, 8'h00);
        periph <= '1;
        vec(16'hFFF8);
        for (int k = 0; k < 5; k++) begin
            power_rst <= (k == 0);
            nm_src <= exc_vec_pkg::nonmaskable_t'(4'hF >> (k - int'(k != 0)));
            vec(16'hFFFE - 16'(2 * k));
        end
        power_rst <= 1'b0;
        nm_src <= '0;
        periph <= 57'h6;
        masks(1'b1, 1'b0);
        wr(8'h1F, 8'hEE);
        rd(8'h1F, 8'hF2);
        vec(16'hFFF0);
        masks(1'b0, 1'b0);
        wr(8'h1F, 8'hEE);
        rd(8'h1F, 8'hEE);
        vec(16'hFFF8);
        masks(1'b1, 1'b0);
        vec(16'hFFEE);
        masks(1'b0, 1'b0);
        wr(8'h1F, 8'hF4);
        masks(1'b1, 1'b0);
        vec(16'hFFF0);
        // reserved slots 17 to 19 must never answer
        foreach (slots[j]) begin
            periph <= 57'h1 << slots[j];
            vec((slots[j] > 16 && slots[j] < 20) ? 16'hFFF8
                : 16'hFFF2 - 16'(2 * slots[j]));
        end
        masks(1'b0, 1'b1);
        periph <= '0;
        pin(2);
        vec(16'hFFF4);
        masks(1'b0, 1'b0);
        pin(2);
        vec(16'hFFF8);
        masks(1'b0, 1'b1);
        vec(16'hFFF4);
        masks(1'b1, 1'b0);
        pin(0);
        vec(16'hFFF2);
        cycles(8);
        vec(16'hFFF8);
        wr(8'h1E, 8'hC0);
        rd(8'h1E, 8'hC0);
        pin(0);
        pin(1);
        vec(16'hFFF2);
        vec(16'hFFF8);
        wr(8'h1E, 8'h40);
        rd(8'h1E, 8'hC0);
        wr(8'h1E, 8'h80);
        pin(0);
        pin(1);
        vec(16'hFFF8);
        special <= 1'b1;
        wr(8'h1E, 8'h40);
        rd(8'h1E, 8'h40);
        conclude();
    end

    // run limit: the sequence needs well under a thousand cycles
    initial begin
        cycles(3000);
        n_mismatch++;
        conclude();
    end
endmodule : tb_top
